// File: design/ttc_regs.sv
// touch threshold config register bank with per-channel threshold derivation
// assumes: protocol engine presents one byte access per cycle, synchronous to sys_clk_i
//
// How it works
// R1: each channel threshold equals start plus step times channel level.
// R2: start register is 8-bit read/write, resets to 0x14, plain unsigned.
// R3: step register is 8-bit read/write, resets to 0x14, plain unsigned.
// R4: two 3-bit levels per byte: odd in bits 6..4, even 2..0.
// R5: channel 0/1 byte sits at offset 0x02, next five hold channels 2..11.
// R6: level 000 most sensitive, 111 least; each resets to 011.
// R7: start and step are taken up only when a level byte is written.
// R8: threshold math is 11-bit unsigned and cannot overflow.
`timescale 1ns/1ps
`default_nettype none

module ttc_regs
  import ttc_pkg::*;
#(
  parameter int NUM_CH = NCH
)(
  input  wire logic                 sys_clk_i, // 100 MHz core clock
  input  wire logic                 nrst_i,    // async reset, active low
  input  wire logic                 ce_i,      // clock enable, freezes state
  input  wire ttc_req_t             req_i,     // register access request
  output logic [DW-1:0]             rdata_o,   // read data, registered
  output logic                      rvalid_o,  // read data valid pulse
  output logic [NUM_CH-1:0][THRW-1:0] thr_o    // per-channel thresholds
);

  // ********************************************
  // decode helpers
  // ********************************************
  function automatic logic is_sens(input logic [AW-1:0] a);
    logic [AW-1:0] off;
    off = a - ADDR_SENS0;
    return (a >= ADDR_SENS0) && (off < AW'(NPAIR)); // [R5]
  endfunction

  function automatic logic [MIXW:0] misc_idx(input logic [AW-1:0] a);
    logic [MIXW:0] r;
    r = '0;
    for (int i = 0; i < NMISC; i++)
    begin
      if (MISC_ADDR[i] == a)
      begin
        r = {1'b1, MIXW'(i)};
      end
    end
    return r;
  endfunction

  function automatic logic [THRW-1:0] calc_thr(
    input logic [DW-1:0]   start,
    input logic [DW-1:0]   step,
    input logic [LVLW-1:0] lvl
  );
    logic [THRW-1:0] prod;
    prod = THRW'(step) * THRW'(lvl); // [R8]
    return THRW'(start) + prod;      // [R1]
  endfunction

  // ********************************************
  // request decode
  // ********************************************
  logic                 wr_en;
  logic                 rd_en;
  logic                 sens_hit;
  logic [AW-1:0]        sens_off;
  logic [MIXW:0]        mix;

  assign wr_en    = ce_i && req_i.wr;
  assign rd_en    = ce_i && req_i.rd;
  assign sens_hit = is_sens(req_i.addr);
  assign sens_off = req_i.addr - ADDR_SENS0;
  assign mix      = misc_idx(req_i.addr);

  // ********************************************
  // start and step registers
  // ********************************************
  logic [DW-1:0] start_q;
  logic [DW-1:0] step_q;

  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      start_q <= RST_START; // [R2]
      step_q  <= RST_STEP;  // [R3]
    end
    else if (wr_en)
    begin
      if (req_i.addr == ADDR_START)
      begin
        start_q <= req_i.wdata; // [R2]
      end
      if (req_i.addr == ADDR_STEP)
      begin
        step_q <= req_i.wdata; // [R3]
      end
    end
  end

  // ********************************************
  // level registers, two channels per byte
  // ********************************************
  logic [NPAIR-1:0][1:0][LVLW-1:0] lvl_q;

  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      lvl_q <= {(NPAIR*2){RST_LEVEL}}; // [R6]
    end
    else if (wr_en && sens_hit)
    begin
      lvl_q[sens_off[2:0]][0] <= req_i.wdata[EVEN_LSB +: LVLW]; // [R4]
      lvl_q[sens_off[2:0]][1] <= req_i.wdata[ODD_LSB +: LVLW];  // [R4]
    end
  end

  // ********************************************
  // working copies of start and step
  // ********************************************
  // a threshold edit alone leaves detection untouched until a level byte
  // is rewritten; software must follow up with that rewrite
  logic [DW-1:0] start_use_q;
  logic [DW-1:0] step_use_q;

  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      start_use_q <= RST_START;
      step_use_q  <= RST_STEP;
    end
    else if (wr_en && sens_hit)
    begin
      // same-cycle start write cannot coincide: one access per cycle
      start_use_q <= start_q; // [R7]
      step_use_q  <= step_q;  // [R7]
    end
  end

  // ********************************************
  // threshold derivation
  // ********************************************
  logic [NUM_CH-1:0][THRW-1:0] thr_q;

  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      thr_q <= '0;
    end
    else if (ce_i)
    begin
      for (int c = 0; c < NUM_CH; c++)
      begin
        thr_q[c] <= calc_thr(start_use_q, step_use_q, lvl_q[c/2][c%2]); // [R1]
      end
    end
  end

  assign thr_o = thr_q;

  // ********************************************
  // storage for the remaining map entries
  // ********************************************
  logic [NMISC-1:0][DW-1:0] misc_q;

  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      for (int i = 0; i < NMISC; i++)
      begin
        misc_q[i] <= (MISC_ADDR[i] == ADDR_CTRL_A) ? RST_CTRL_A : RST_MISC;
      end
    end
    else if (wr_en && mix[MIXW])
    begin
      misc_q[mix[MIXW-1:0]] <= req_i.wdata;
    end
  end

  // ********************************************
  // read path
  // ********************************************
  logic [DW-1:0] rd_mux;
  logic [DW-1:0] rdata_q;
  logic          rvalid_q;

  always_comb
  begin
    rd_mux = RD_UNMAPPED;
    if (req_i.addr == ADDR_START)
    begin
      rd_mux = start_q;
    end
    else if (req_i.addr == ADDR_STEP)
    begin
      rd_mux = step_q;
    end
    else if (sens_hit)
    begin
      rd_mux = '0;
      rd_mux[EVEN_LSB +: LVLW] = lvl_q[sens_off[2:0]][0]; // [R4]
      rd_mux[ODD_LSB +: LVLW]  = lvl_q[sens_off[2:0]][1]; // [R4]
    end
    else if (mix[MIXW])
    begin
      rd_mux = misc_q[mix[MIXW-1:0]];
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      rdata_q  <= '0;
      rvalid_q <= 1'b0;
    end
    else if (ce_i)
    begin
      rvalid_q <= req_i.rd;
      if (req_i.rd)
      begin
        rdata_q <= rd_mux;
      end
    end
  end

  assign rdata_o  = rdata_q;
  assign rvalid_o = rvalid_q;

  // ********************************************
  // checks
  // ********************************************
  chk_thr_formula: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // [R1]
    ce_i |=> thr_q[1] == THRW'($past(start_use_q))
             + THRW'($past(step_use_q)) * THRW'($past(lvl_q[0][1])))
    else $error("channel 1 threshold does not match start plus step times level");

  chk_start_write: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // [R2]
    (wr_en && req_i.addr == ADDR_START) |=> start_q == $past(req_i.wdata))
    else $error("start register did not take the written byte");

  chk_step_write: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // [R3]
    (wr_en && req_i.addr == ADDR_STEP) |=> step_q == $past(req_i.wdata))
    else $error("step register did not take the written byte");

  chk_level_reserved: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // [R4]
    (rd_en && sens_hit) |=> rvalid_q && ((rdata_q & ~SENS_MASK) == '0))
    else $error("reserved level bits read back nonzero");

  chk_pair0_offset: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // [R5]
    (wr_en && req_i.addr == ADDR_SENS0)
      |=> lvl_q[0][0] == $past(req_i.wdata[EVEN_LSB +: LVLW])
          && lvl_q[0][1] == $past(req_i.wdata[ODD_LSB +: LVLW]))
    else $error("pair 0 level byte not stored at its offset");

  chk_level_reset: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // [R6]
    $rose(nrst_i) |-> lvl_q[NPAIR-1][1] == RST_LEVEL && lvl_q[0][0] == RST_LEVEL)
    else $error("level fields not at normal level after reset");

  chk_copy_hold: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // [R7]
    (ce_i && !(req_i.wr && sens_hit)) ##1 ce_i
      |-> $stable(start_use_q) && $stable(step_use_q) ##1 $stable(thr_q))
    else $error("threshold inputs changed without a level write");

  chk_no_wrap: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // [R8]
    ce_i |=> thr_q[0] >= THRW'($past(start_use_q)) && thr_q[NUM_CH-1] >= THRW'($past(start_use_q)))
    else $error("threshold sum wrapped below start value");

  // reset values are only looked at on the first edge after release
  chk_start_reset: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // [R2]
    $rose(nrst_i)
      |-> start_q == RST_START)
    else $error("start register not at its reset value after reset");

  chk_step_reset: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // [R3]
    $rose(nrst_i)
      |-> step_q == RST_STEP)
    else $error("step register not at its reset value after reset");

  chk_pair_fields: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // [R4]
    (wr_en && sens_hit)
      |=> lvl_q[$past(sens_off[2:0])] == {$past(req_i.wdata[ODD_LSB +: LVLW]),
                                          $past(req_i.wdata[EVEN_LSB +: LVLW])})
    else $error("level byte fields not stored in their pair slot");

  chk_read_pulse: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    ce_i
      |=> rvalid_q == $past(req_i.rd))
    else $error("read valid did not follow the accepted read by one cycle");

  // copy must be the registers as they stood before the level write
  chk_copy_take: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // [R7]
    (wr_en && sens_hit)
      |=> start_use_q == $past(start_q) && step_use_q == $past(step_q))
    else $error("working copies did not take start and step on a level write");

endmodule

`default_nettype wire

// File: inc/ttc_pkg.sv
// touch threshold config: shared constants, register map and request carrier
// assumes: byte-wide register port driven by the serial protocol engine
package ttc_pkg;

  // ********************************************
  // widths and counts
  // ********************************************
  localparam int DW    = 8;
  localparam int AW    = 8;
  localparam int NCH   = 12;
  localparam int NPAIR = 6;
  localparam int LVLW  = 3;
  localparam int THRW  = 11;
  localparam int NMISC = 23;
  localparam int MIXW  = 5;

  // ********************************************
  // threshold and level registers
  // ********************************************
  localparam logic [AW-1:0] ADDR_START = 8'h00;
  localparam logic [AW-1:0] ADDR_STEP  = 8'h01;
  localparam logic [AW-1:0] ADDR_SENS0 = 8'h02;
  localparam logic [DW-1:0] RST_START  = 8'h14;
  localparam logic [DW-1:0] RST_STEP   = 8'h14;
  localparam logic [LVLW-1:0] RST_LEVEL = 3'h3;
  localparam logic [DW-1:0] SENS_MASK  = 8'h77;
  localparam int EVEN_LSB = 0;
  localparam int ODD_LSB  = 4;

  // ********************************************
  // plain storage registers, in map order
  // ********************************************
  localparam logic [AW-1:0] MISC_ADDR [NMISC] = '{
    8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h10, 8'h11,
    8'h12, 8'h13, 8'h14, 8'h15, 8'h1D, 8'h1E, 8'h1F, 8'h20,
    8'h23, 8'h24, 8'h25, 8'h26, 8'h27, 8'h2A, 8'hFE};
  localparam logic [AW-1:0] ADDR_CTRL_A = 8'h08;
  localparam logic [DW-1:0] RST_CTRL_A  = 8'h80;
  localparam logic [DW-1:0] RST_MISC    = 8'h00;
  localparam logic [DW-1:0] RD_UNMAPPED = 8'h00;

  typedef struct packed {
    logic          wr;
    logic          rd;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
  } ttc_req_t;

endpackage

// File: tb/ttc_host.sv
// host model: issues one byte register access per cycle
// assumes: tasks are entered 1 ns after a rising edge
`timescale 1ns/1ps
`default_nettype none

module ttc_host
  import ttc_pkg::*;
(
  input  wire logic          clk_i,    // core clock
  output var  ttc_req_t      req_o,    // access request
  input  wire logic [DW-1:0] rdata_i,  // read data
  input  wire logic          rvalid_i  // read valid pulse
);
  // ****************************************
  // request driver
  // ****************************************
  initial req_o = '0;

  task automatic xfer(input logic w, input logic r, input logic [AW-1:0] a,
                      input logic [DW-1:0] d, output logic [DW-1:0] q, output logic v);
    req_o <= '{wr: w, rd: r, addr: a, wdata: d};
    @(posedge clk_i);
    #1;
    q = rdata_i;
    v = rvalid_i;
  endtask

  // released lines flip, so a stale address can never look valid
  task automatic idle;
    req_o <= '{wr: 1'b0, rd: 1'b0, addr: ~req_o.addr, wdata: ~req_o.wdata};
    @(posedge clk_i);
    #1;
  endtask
endmodule

`default_nettype wire

// File: tb/ttc_regs_test.sv
// bench for the threshold config bank: table of accesses, then edge cases
// assumes: host model in ttc_host, design ttc_regs
`timescale 1ns/1ps
`default_nettype none

module ttc_regs_test
  import ttc_pkg::*;
;
  logic                     sys_clk;
  logic                     nrst;
  logic                     ce;
  ttc_req_t                 req;
  logic [DW-1:0]            rdata;
  logic                     rvalid;
  logic [NCH-1:0][THRW-1:0] thr;
  int                       failures;
  int                       total_checks;
  logic [DW-1:0]            st, sp, cst, csp, q;
  logic                     v;
  logic [LVLW-1:0]          lv [NCH];
  logic [23:0]              rows [9] = '{24'h00FFFF, 24'h01FFFF, 24'h027777, 24'h03F070,
    24'h070F07, 24'h0E5A00, 24'h2AA5A5, 24'hFE0101, 24'h080000};

  ttc_regs #(.NUM_CH(NCH)) dut (.sys_clk_i(sys_clk), .nrst_i(nrst), .ce_i(ce), .req_i(req),
    .rdata_o(rdata), .rvalid_o(rvalid), .thr_o(thr));
  ttc_host host (.clk_i(sys_clk), .req_o(req), .rdata_i(rdata), .rvalid_i(rvalid));

  // ****************************************
  // helpers
  // ****************************************
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    total_checks++;
    if (s !== e)
    begin
      failures++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic wrap_up;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic model_reset;
    st = 8'h14; sp = 8'h14; cst = 8'h14; csp = 8'h14;
    foreach (lv[c]) lv[c] = 3'h3;
  endtask

  // level writes recopy start and step as they stood before the edge
  task automatic w(input logic [AW-1:0] a, input logic [DW-1:0] d);
    int k;
    k = int'(a) - int'(ADDR_SENS0);
    host.xfer(1'b1, 1'b0, a, d, q, v);
    if (k >= 0 && k < NPAIR)
    begin
      lv[2*k] = d[2:0];
      lv[2*k+1] = d[6:4];
      cst = st;
      csp = sp;
    end
    if (a == ADDR_START) st = d;
    if (a == ADDR_STEP) sp = d;
  endtask

  task automatic r(input logic [AW-1:0] a, input logic [DW-1:0] e);
    host.xfer(1'b0, 1'b1, a, 8'h00, q, v);
    chk("rvalid", 16'(v), 16'h0001);
    chk("rdata", 16'(q), 16'(e));
  endtask

  task automatic thr_all;
    logic [THRW-1:0] e;
    foreach (lv[c])
    begin
      e = 11'(cst) + 11'(csp) * 11'(lv[c]);
      chk("thr", 16'(thr[c]), 16'(e));
    end
  endtask

  // ****************************************
  // sequence
  // ****************************************
  initial
  begin
    #50000;
    failures++;
    wrap_up();
  end

  initial
  begin
    failures = 0;
    total_checks = 0;
    ce = 1'b1;
    nrst = 1'b0;
    model_reset();
    repeat (6) @(posedge sys_clk);
    #1;
    nrst = 1'b1;
    host.idle();
    thr_all();
    chk("rvalid", 16'(rvalid), 16'h0000);
    for (int a = 0; a < 10; a++)
      r(8'(a), a < 2 ? 8'h14 : (a < 8 ? 8'h33 : (a == 8 ? 8'h80 : 8'h00)));
    $display("reset test done");
    foreach (rows[i])
    begin
      w(rows[i][23:16], rows[i][15:8]);
      r(rows[i][23:16], rows[i][7:0]);
    end
    host.idle();
    thr_all();
    chk("rvalid", 16'(rvalid), 16'h0000);
    $display("table test done");
    w(ADDR_START, 8'h64);
    w(ADDR_STEP, 8'h0A);
    host.idle();
    thr_all();
    // host side: rewrite a level byte so the new thresholds are taken up
    w(ADDR_SENS0, 8'h55);
    host.idle();
    thr_all();
    chk("thr0", 16'(thr[0]), 16'd150);
    $display("reload test done");
    ce = 1'b0;
    host.xfer(1'b1, 1'b0, ADDR_START, 8'h11, q, v);
    ce = 1'b1;
    r(ADDR_START, 8'h64);
    $display("enable test done");
    nrst = 1'b0;
    model_reset();
    host.idle();
    nrst = 1'b1;
    host.idle();
    thr_all();
    r(ADDR_START, 8'h14);
    r(8'h07, 8'h33);
    $display("second reset test done");
    wrap_up();
  end
endmodule

`default_nettype wire
